// ### src/pxb_cfg.svh
// pxb_cfg.svh: constants for the priority crossbar pin assigner
// assumes: included by the package and the crossbar top, nothing else
`ifndef PXB_CFG_SVH
`define PXB_CFG_SVH

// ======================================================================
// pin counts
`define PXB_NPIN 25
`define PXB_NXPIN 20
`define PXB_NSIG 21
`define PXB_MAPW 5
`define PXB_UART_TX_PIN 4
`define PXB_UART_RX_PIN 5
`define PXB_NCEX 5
// fixed gpio pins watched by the driver checks
`define PXB_OD_PIN 21
`define PXB_AN_PIN 22

// ======================================================================
// signal indices, highest priority first
`define PXB_S_TX 0
`define PXB_S_RX 1
`define PXB_S_SCK 2
`define PXB_S_MISO 3
`define PXB_S_MOSI 4
`define PXB_S_NSS 5
`define PXB_S_SDA 6
`define PXB_S_SCL 7
`define PXB_S_CP0 8
`define PXB_S_COMPARATOR0_ASYNC_OUT 9
`define PXB_S_CP1 10
`define PXB_S_COMPARATOR1_ASYNC_OUT 11
`define PXB_S_SYSCLK 12
`define PXB_S_COUNTER_MODULE_OUT0 13
`define PXB_S_ECI 18
`define PXB_S_T0 19
`define PXB_S_T1 20

// ======================================================================
// select register a fields
`define PXB_A_UART 0
`define PXB_A_SPI 1
`define PXB_A_SMB 2
`define PXB_A_SYSCLK 3
`define PXB_A_CP0 4
`define PXB_A_COMPARATOR0_ASYNC_OUT 5
`define PXB_A_CP1 6
`define PXB_A_COMPARATOR1_ASYNC_OUT 7

// ======================================================================
// select register b fields
`define PXB_B_CEX_LO 0
`define PXB_B_CEX_HI 2
`define PXB_B_CEX_MAX 3'h5
`define PXB_B_ECI 3
`define PXB_B_T0 4
`define PXB_B_T1 5
`define PXB_B_WPUD 6
`define PXB_B_ENABLE 7

`endif

// ### src/pxb_pkg.sv
// pxb_pkg.sv: types shared by the crossbar and its bench
// assumes: pxb_cfg.svh on the include path
`include "pxb_cfg.svh"
`default_nettype none

package pxb_pkg;
  typedef logic [`PXB_NSIG-1:0] pxb_sig_t;
  typedef logic [`PXB_NPIN-1:0] pxb_pins_t;
  typedef logic [`PXB_MAPW-1:0] pxb_map_t;
  // one bundle of pin drive
  typedef struct packed {
    pxb_pins_t dout;
    pxb_pins_t doe;
  } pxb_drive_s;
endpackage : pxb_pkg

`default_nettype wire

// ### src/pxb_crossbar.sv
// pxb_crossbar.sv: priority crossbar, pin driver mode and port read-back
// assumes: all inputs synchronous to CLK; pin pads resolve level from DOUT/DOE
//
// Behaviour
// [RULE_01] only pins P0.0 to P2.3 may carry peripheral signals
// [RULE_02] each pin is digital I/O or analog input, per mode bit
// [RULE_03] port read always returns the pin state, whatever is routed; code returns 0 for pins in analog mode
// [RULE_04] signals are processed in fixed priority, serial port first
// [RULE_05] each enabled signal takes the lowest free, unskipped pin
// [RULE_06] serial transmit and receive always sit on P0.4 and P0.5
// [RULE_07] an allocated pin is excluded for all later signals
// [RULE_08] pins with skip bit set are passed over
// [RULE_09] a skipped pin counts exactly as an allocated one
// [RULE_10] software skips pins used outside the crossbar
// [RULE_11] special-function signals never allocated; software skips their pins
// [RULE_12] skip mask 0x0c on port 0 moves allocation past bits 2 and 3
// [RULE_13] per-pin push-pull or open-drain output mode for ports 0-3
// [RULE_14] two select registers choose which signals take part
// [RULE_15] two-wire and serial port each take both their pins together
// [RULE_16] master enable clear leaves all pins as input port I/O; code turns off the drivers of P0.0 to P2.3 only
// [RULE_17] slave select takes a pin only in 4-wire mode
// [RULE_18] order: serial, spi, two-wire, comparators, sysclk, counters, eci, timers
// [RULE_19] skip masks 8/8/4 bits; signals without a free pin stay unconnected
`include "pxb_cfg.svh"
`default_nettype none

module pxb_crossbar (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] XBAR_SELECT_REG_A,
  input wire logic [7:0] XBAR_SELECT_REG_B,
  input wire logic [7:0] PORT0_SKIP_MASK,
  input wire logic [7:0] PORT1_SKIP_MASK,
  input wire logic [3:0] PORT2_SKIP_MASK,
  input wire logic SPI_FOUR_WIRE,
  input wire pxb_pkg::pxb_pins_t PORT_OUTPUT_MODE,
  input wire pxb_pkg::pxb_pins_t PORT_DIGITAL_MODE,
  input wire pxb_pkg::pxb_pins_t PORT_LATCH_OUT,
  input wire pxb_pkg::pxb_pins_t PIN_IN,
  input wire pxb_pkg::pxb_sig_t PERIPH_OUT,
  input wire pxb_pkg::pxb_sig_t PERIPH_OE,
  output var pxb_pkg::pxb_drive_s PIN_DRIVE,
  output var pxb_pkg::pxb_pins_t PIN_PULLUP,
  output var pxb_pkg::pxb_pins_t PORT_READ,
  output var pxb_pkg::pxb_sig_t PERIPH_IN
);
  import pxb_pkg::*;

  // ====================================================================
  // enabled signal set
  pxb_sig_t want;
  logic [2:0] cex_count;
  always_comb begin
    want = '0;
    cex_count = XBAR_SELECT_REG_B[`PXB_B_CEX_HI:`PXB_B_CEX_LO];
    if (cex_count > `PXB_B_CEX_MAX) begin
      cex_count = `PXB_B_CEX_MAX;
    end
    want[`PXB_S_TX] = XBAR_SELECT_REG_A[`PXB_A_UART]; // RULE_14
    want[`PXB_S_RX] = XBAR_SELECT_REG_A[`PXB_A_UART]; // RULE_15
    want[`PXB_S_SCK] = XBAR_SELECT_REG_A[`PXB_A_SPI];
    want[`PXB_S_MISO] = XBAR_SELECT_REG_A[`PXB_A_SPI];
    want[`PXB_S_MOSI] = XBAR_SELECT_REG_A[`PXB_A_SPI];
    want[`PXB_S_NSS] = XBAR_SELECT_REG_A[`PXB_A_SPI] & SPI_FOUR_WIRE; // RULE_17
    want[`PXB_S_SDA] = XBAR_SELECT_REG_A[`PXB_A_SMB]; // RULE_15
    want[`PXB_S_SCL] = XBAR_SELECT_REG_A[`PXB_A_SMB];
    want[`PXB_S_CP0] = XBAR_SELECT_REG_A[`PXB_A_CP0];
    want[`PXB_S_COMPARATOR0_ASYNC_OUT] = XBAR_SELECT_REG_A[`PXB_A_COMPARATOR0_ASYNC_OUT];
    want[`PXB_S_CP1] = XBAR_SELECT_REG_A[`PXB_A_CP1];
    want[`PXB_S_COMPARATOR1_ASYNC_OUT] = XBAR_SELECT_REG_A[`PXB_A_COMPARATOR1_ASYNC_OUT];
    want[`PXB_S_SYSCLK] = XBAR_SELECT_REG_A[`PXB_A_SYSCLK];
    for (int c = 0; c < `PXB_NCEX; c++) begin
      want[`PXB_S_COUNTER_MODULE_OUT0 + c] = (3'(c) < cex_count);
    end
    want[`PXB_S_ECI] = XBAR_SELECT_REG_B[`PXB_B_ECI];
    want[`PXB_S_T0] = XBAR_SELECT_REG_B[`PXB_B_T0];
    want[`PXB_S_T1] = XBAR_SELECT_REG_B[`PXB_B_T1];
  end

  // ====================================================================
  // priority decode; map entry is signal index plus one, zero for none
  logic [`PXB_NXPIN-1:0] skip_all;
  logic [`PXB_NXPIN-1:0] taken;
  logic [`PXB_NXPIN-1:0][`PXB_MAPW-1:0] next_map;
  logic found;
  assign skip_all = {PORT2_SKIP_MASK, PORT1_SKIP_MASK, PORT0_SKIP_MASK}; // RULE_19
  always_comb begin
    taken = skip_all; // RULE_08 RULE_09 RULE_11 RULE_12
    next_map = '0;
    found = 1'b0;
    if (XBAR_SELECT_REG_B[`PXB_B_ENABLE]) begin // RULE_16
      // serial pins are fixed so a bootloader always finds them
      if (want[`PXB_S_TX]) begin // RULE_06
        next_map[`PXB_UART_TX_PIN] = `PXB_MAPW'(`PXB_S_TX + 1);
        next_map[`PXB_UART_RX_PIN] = `PXB_MAPW'(`PXB_S_RX + 1);
        taken[`PXB_UART_TX_PIN] = 1'b1;
        taken[`PXB_UART_RX_PIN] = 1'b1;
      end
      for (int s = `PXB_S_SCK; s < `PXB_NSIG; s++) begin // RULE_04 RULE_18
        found = 1'b0;
        if (want[s]) begin
          for (int p = 0; p < `PXB_NXPIN; p++) begin // RULE_01
            if (!found && !taken[p]) begin // RULE_05
              next_map[p] = `PXB_MAPW'(s + 1);
              taken[p] = 1'b1; // RULE_07
              found = 1'b1;
            end
          end
        end
      end
    end
  end

  logic [`PXB_NXPIN-1:0][`PXB_MAPW-1:0] map;
  logic en_q;
  logic wpud_q;
  logic [`PXB_NXPIN-1:0] skip_q;
  logic uart_q;
  logic spi_q;
  logic nss_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      map <= '0;
      en_q <= 1'b0;
      wpud_q <= 1'b0;
      skip_q <= '0;
      uart_q <= 1'b0;
      spi_q <= 1'b0;
      nss_q <= 1'b0;
    end else begin
      map <= next_map;
      en_q <= XBAR_SELECT_REG_B[`PXB_B_ENABLE];
      wpud_q <= XBAR_SELECT_REG_B[`PXB_B_WPUD];
      skip_q <= skip_all;
      uart_q <= want[`PXB_S_TX];
      spi_q <= want[`PXB_S_SCK];
      nss_q <= want[`PXB_S_NSS];
    end
  end

  // ====================================================================
  // pin drivers and routed inputs
  pxb_drive_s next_drive;
  pxb_pins_t next_pullup;
  pxb_sig_t next_periph_in;
  logic [`PXB_MAPW-1:0] idx;
  logic od;
  logic val;
  logic drv;
  always_comb begin
    next_drive = '0;
    next_pullup = '0;
    next_periph_in = '1; // unconnected inputs idle high
    idx = '0;
    od = 1'b0;
    val = 1'b0;
    drv = 1'b0;
    for (int p = 0; p < `PXB_NPIN; p++) begin
      // modulo keeps the map index in range for the gpio-only pins
      idx = (p < `PXB_NXPIN) ? map[p % `PXB_NXPIN] : '0;
      od = !PORT_OUTPUT_MODE[p]; // RULE_13
      val = PORT_LATCH_OUT[p];
      drv = 1'b1;
      if (idx != '0) begin
        val = PERIPH_OUT[idx - 1'b1];
        drv = PERIPH_OE[idx - 1'b1];
        // two-wire pins are open-drain whatever the mode bit says
        if ((idx == `PXB_MAPW'(`PXB_S_SDA + 1)) || (idx == `PXB_MAPW'(`PXB_S_SCL + 1))) begin
          od = 1'b1;
        end
        next_periph_in[idx - 1'b1] = PIN_IN[p] & PORT_DIGITAL_MODE[p];
      end
      // output drivers of crossbar pins stay off until it is enabled
      if (p < `PXB_NXPIN && !en_q) begin // RULE_16
        drv = 1'b0;
      end
      drv = drv & PORT_DIGITAL_MODE[p]; // RULE_02
      next_drive.doe[p] = drv & (od ? !val : 1'b1);
      next_drive.dout[p] = od ? 1'b0 : val;
      // pull-up off while driving low to save power
      next_pullup[p] = !wpud_q & od & PORT_DIGITAL_MODE[p] & !next_drive.doe[p];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIN_DRIVE <= '0;
      PIN_PULLUP <= '0;
      PERIPH_IN <= '1;
    end else begin
      PIN_DRIVE <= next_drive;
      PIN_PULLUP <= next_pullup;
      PERIPH_IN <= next_periph_in;
    end
  end

  // analog pins have their receiver off and read low
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_READ <= '0;
    end else begin
      PORT_READ <= PIN_IN & PORT_DIGITAL_MODE; // RULE_03
    end
  end

  // ====================================================================
  // checks
  logic [`PXB_NXPIN-1:0] free_q;
  logic [`PXB_MAPW-1:0] first_free;
  logic got;
  logic skip_hit;
  logic nss_placed;
  always_comb begin
    free_q = ~skip_q;
    first_free = '0;
    got = 1'b0;
    skip_hit = 1'b0;
    nss_placed = 1'b0;
    if (uart_q) begin
      free_q[`PXB_UART_TX_PIN] = 1'b0;
      free_q[`PXB_UART_RX_PIN] = 1'b0;
    end
    for (int p = 0; p < `PXB_NXPIN; p++) begin
      if (!got && free_q[p]) begin
        first_free = `PXB_MAPW'(p);
        got = 1'b1;
      end
      // only the fixed serial pins may land on a skipped pin
      if (skip_q[p] && (map[p] != '0)) begin
        skip_hit = skip_hit |
          !(uart_q && en_q && (p == `PXB_UART_TX_PIN || p == `PXB_UART_RX_PIN));
      end
      if (map[p] == `PXB_MAPW'(`PXB_S_NSS + 1)) begin
        nss_placed = 1'b1;
      end
    end
  end

  sequence s_disabled;
    !en_q;
  endsequence
  sequence s_xpins_quiet;
    ##1 (PIN_DRIVE.doe[`PXB_NXPIN-1:0] == '0);
  endsequence

  property p_off_inputs;
    @(posedge CLK) disable iff (!RST_B) s_disabled |-> s_xpins_quiet;
  endproperty
  a_off_inputs: assert property (p_off_inputs) else $error("pins driven while disabled"); // RULE_16

  property p_uart_fixed;
    @(posedge CLK) disable iff (!RST_B) (en_q && uart_q) |->
      (map[`PXB_UART_TX_PIN] == `PXB_MAPW'(`PXB_S_TX + 1)) &&
      (map[`PXB_UART_RX_PIN] == `PXB_MAPW'(`PXB_S_RX + 1));
  endproperty
  a_uart_fixed: assert property (p_uart_fixed) else $error("serial pins misplaced"); // RULE_06

  property p_skip_honoured;
    @(posedge CLK) disable iff (!RST_B) 1'b1 |-> !skip_hit;
  endproperty
  a_skip_honoured: assert property (p_skip_honoured) else $error("skip mask lost"); // RULE_08

  property p_skip_empty;
    @(posedge CLK) disable iff (!RST_B) (skip_q[0] && !(uart_q && en_q)) |-> map[0] == '0;
  endproperty
  a_skip_empty: assert property (p_skip_empty) else $error("skipped pin allocated"); // RULE_09

  property p_lowest_free;
    @(posedge CLK) disable iff (!RST_B) (en_q && spi_q && got) |->
      map[first_free] == `PXB_MAPW'(`PXB_S_SCK + 1);
  endproperty
  a_lowest_free: assert property (p_lowest_free) else $error("clock not on lowest pin"); // RULE_05

  property p_nss_only_four;
    @(posedge CLK) disable iff (!RST_B) !nss_q |-> !nss_placed;
  endproperty
  a_nss_only_four: assert property (p_nss_only_four) else $error("slave select placed"); // RULE_17

  property p_read_back;
    @(posedge CLK) disable iff (!RST_B) 1'b1 |=>
      PORT_READ == ($past(PIN_IN) & $past(PORT_DIGITAL_MODE));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read-back wrong"); // RULE_03

  property p_open_drain_high;
    @(posedge CLK) disable iff (!RST_B)
      (!PORT_OUTPUT_MODE[`PXB_OD_PIN] && PORT_LATCH_OUT[`PXB_OD_PIN]) |=>
      !PIN_DRIVE.doe[`PXB_OD_PIN];
  endproperty
  a_open_drain_high: assert property (p_open_drain_high) else $error("open-drain drove high"); // RULE_13

  property p_analog_quiet;
    @(posedge CLK) disable iff (!RST_B) !PORT_DIGITAL_MODE[`PXB_AN_PIN] |=>
      !PIN_DRIVE.doe[`PXB_AN_PIN];
  endproperty
  a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin driven"); // RULE_02

endmodule : pxb_crossbar

`default_nettype wire

// ### bench/pxb_pad_model.sv
// pxb_pad_model.sv: pad and board model on the far side of the crossbar
// assumes: drive and pull-up come straight from the crossbar outputs
`default_nettype none

module pxb_pad_model (
  input wire pxb_pkg::pxb_drive_s drv,
  input wire pxb_pkg::pxb_pins_t pull,
  input wire pxb_pkg::pxb_pins_t ext,
  output var pxb_pkg::pxb_pins_t lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  import pxb_pkg::*;
  // ==========
  // pad level
  // driver wins; a released line floats to the pull-up, else the board value
  assign lvl = (drv.doe & drv.dout) | (~drv.doe & (pull | ext));
endmodule : pxb_pad_model

`default_nettype wire

// ### bench/test_priority_crossbar_pin_assigner.sv
// test_priority_crossbar_pin_assigner.sv: self-checking bench for pxb_crossbar
// assumes: pxb_pkg and pxb_pad_model compiled first; assertions live in the design
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end

module test_priority_crossbar_pin_assigner;
  timeunit 1ns;
  timeprecision 1ps;
  import pxb_pkg::*;
  typedef struct packed {
    logic [49:0] drv;
    pxb_pins_t pu;
    pxb_pins_t rd;
    pxb_sig_t pin;
  } pxb_note_s;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic four = 1'b0;
  logic [7:0] sel_a = 8'h0, sel_b = 8'h0, sk0 = 8'h0, sk1 = 8'h0;
  logic [3:0] sk2 = 4'h0;
  pxb_pins_t omode = '0, dmode = '0, latch = '0, ext = '0, lvl, pull, prd;
  pxb_sig_t pout = '0, poe = '0, pin_in;
  pxb_drive_s drive;
  pxb_note_s q[$];
  pxb_note_s nt;
  logic [15:0] seed = 16'h745a;
  int err_total = 0;
  int checked = 0;
  int own[25];
  // config word: four-wire, select a, select b, skip 0, skip 1, skip 2
  logic [36:0] tbl[7] = '{
    {1'b0, 8'h01, 8'h80, 8'h00, 8'h00, 4'h0},
    {1'b0, 8'h01, 8'h80, 8'h30, 8'h00, 4'h0},
    {1'b1, 8'h06, 8'h80, 8'h0c, 8'h00, 4'h0},
    {1'b0, 8'h02, 8'h80, 8'h00, 8'h00, 4'h0},
    {1'b1, 8'hff, 8'hbf, 8'h00, 8'h00, 4'h0},
    {1'b1, 8'hff, 8'h3f, 8'h00, 8'h00, 4'h0},
    {1'b1, 8'hfe, 8'hc5, 8'hc4, 8'hff, 4'h7}
  };

  pxb_crossbar dut_u (.CLK(clk), .RST_B(rst_b), .XBAR_SELECT_REG_A(sel_a),
    .XBAR_SELECT_REG_B(sel_b), .PORT0_SKIP_MASK(sk0), .PORT1_SKIP_MASK(sk1),
    .PORT2_SKIP_MASK(sk2), .SPI_FOUR_WIRE(four), .PORT_OUTPUT_MODE(omode),
    .PORT_DIGITAL_MODE(dmode), .PORT_LATCH_OUT(latch), .PIN_IN(lvl),
    .PERIPH_OUT(pout), .PERIPH_OE(poe), .PIN_DRIVE(drive), .PIN_PULLUP(pull),
    .PORT_READ(prd), .PERIPH_IN(pin_in));
  pxb_pad_model pad_u (.drv(drive), .pull(pull), .ext(ext), .lvl(lvl));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] rnd();
    seed = lfsr(seed);
    rnd[15:0] = seed;
    seed = lfsr(seed);
    rnd[31:16] = seed;
  endfunction : rnd

  // ==========
  // reference allocation and pin drive
  task automatic expect_now();
    logic [19:0] used;
    logic [20:0] en;
    pxb_note_s n;
    logic od, d, w, v, u;
    int p;
    used = {sk2, sk1, sk0};
    en = {sel_b[5:3], 5'h0, sel_a[3], sel_a[7:4], {2{sel_a[2]}}, sel_a[1] & four,
      {3{sel_a[1]}}, {2{sel_a[0]}}};
    for (int i = 0; i < 5; i++) en[13 + i] = i < sel_b[2:0];
    for (p = 0; p < 25; p++) own[p] = -1;
    if (sel_b[7] && en[0]) begin
      own[4] = 0;
      own[5] = 1;
      used[5:4] = 2'h3;
    end
    for (int s = 2; s < 21; s++) begin
      p = 0;
      while (p < 20 && used[p]) p++;
      if (sel_b[7] && en[s] && p < 20) begin
        own[p] = s;
        used[p] = 1'b1;
      end
    end
    n.pin = '1;
    for (p = 0; p < 25; p++) begin
      od = !omode[p] || own[p] == 6 || own[p] == 7;
      v = own[p] < 0 ? latch[p] : pout[own[p]];
      w = own[p] < 0 ? 1'b1 : poe[own[p]];
      d = w && !(od && v) && dmode[p] && (p > 19 || sel_b[7]);
      u = !sel_b[6] && od && dmode[p] && !d;
      n.drv[p] = d;
      n.drv[p + 25] = d && !od && v;
      n.pu[p] = u;
      v = d ? !od && v : u || ext[p];
      n.rd[p] = v && dmode[p];
      if (own[p] >= 0) n.pin[own[p]] = n.rd[p];
    end
    q.push_back(n);
  endtask : expect_now

  task automatic apply(input logic [36:0] c);
    {four, sel_a, sel_b, sk0, sk1, sk2} = c;
    omode = pxb_pins_t'(rnd());
    dmode = pxb_pins_t'(rnd() | rnd());
    latch = pxb_pins_t'(rnd());
    ext = pxb_pins_t'(rnd());
    pout = pxb_sig_t'(rnd());
    poe = pxb_sig_t'(rnd());
    repeat (3) @(negedge clk);
    expect_now();
    // inputs hold two more edges so the scoreboard pops before they move
    repeat (2) @(negedge clk);
  endtask : apply

  // outputs change only on a rising edge or on reset assertion, so release at a falling edge is safe
  task automatic reset_check();
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    q.push_back('{50'h0, 25'h0, 25'h0, 21'h1fffff});
    @(negedge clk);
    rst_b = 1'b1;
  endtask : reset_check

  task automatic end_of_test();
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========
  // scoreboard
  always @(negedge clk) begin
    if (q.size() > 0) begin
      nt = q.pop_front();
      `CHK({drive.dout & drive.doe, drive.doe}, nt.drv)
      `CHK(pull, nt.pu)
      `CHK(prd, nt.rd)
      `CHK(pin_in, nt.pin)
    end
  end

  // ==========
  // sequence and watchdog
  initial begin
    @(negedge clk);
    reset_check();
    foreach (tbl[i]) apply(tbl[i]);
    reset_check();
    for (int i = 0; i < 40; i++) apply({rnd(), 5'(rnd())});
    repeat (2) @(negedge clk);
    end_of_test();
  end

  // run is about 250 cycles; this leaves a wide margin
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule : test_priority_crossbar_pin_assigner

`default_nettype wire
